// ==== logic/cdsc_pkg.sv ====
// constants for the clock divider sync control block
// assumes a register write port in the clk_sys domain
`default_nettype none
package cdsc_pkg;
    localparam logic [7:0] ADDR_SYNC_CONTROL = 8'h3A;
    localparam int BIT_MASTER_EN = 0;
    localparam int BIT_GATE = 1;
    localparam int BIT_ONE_SHOT = 2;
    localparam logic [7:0] SYNC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SYNC_CONTROL_WMASK = 8'h07;
    localparam int DIV_RATIO_DEFAULT = 8;
    localparam int PHASE_W = 3;
endpackage : cdsc_pkg
`default_nettype wire

// ==== logic/cdsc_edge.sv ====
// two-flop synchroniser and rising edge detector for the sync pin
// assumes sync_pin is asynchronous to clk_sys
`default_nettype none
module cdsc_edge (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pin and detected edge
    input wire logic sync_pin,
    output logic rise
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } cdsc_edge_t;

    cdsc_edge_t st;
    cdsc_edge_t next_st;

    always_comb begin
        next_st = st;
        next_st.meta = sync_pin;
        next_st.sync = st.meta;
        next_st.last = st.sync;
        if (rst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        st <= next_st;
    end

    // meta is only read by the second flop
    assign rise = st.sync & ~st.last;
endmodule : cdsc_edge
`default_nettype wire

// ==== logic/cdsc_top.sv ====
// sync control register and divider realignment for the converter clock
// assumes register writes and reads arrive as clk_sys-domain strobes
// the divider counter here only models phase; the real divider lies outside
// limitation: sync pin needs at least one low synced cycle between pulses
// How it works
// - Sync pulses do nothing unless the master enable bit is set.
// - With master and gate set, every pulse realigns the divider.
// - With one-shot also set, only the first pulse realigns it.
// - In one-shot mode hardware clears the gate bit when it accepts the pulse.
`default_nettype none
module cdsc_top #(
    parameter int DIV_RATIO = cdsc_pkg::DIV_RATIO_DEFAULT
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // sync pin
    input wire logic sync_pin,
    // divider state and sync buffer enable
    output logic [cdsc_pkg::PHASE_W-1:0] div_phase,
    output logic realign,
    output logic sync_buf_on
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [cdsc_pkg::PHASE_W-1:0] phase;
        logic realign;
        logic [7:0] rdata;
    } cdsc_state_t;

    localparam logic [cdsc_pkg::PHASE_W-1:0] LAST_PHASE =
        cdsc_pkg::PHASE_W'(DIV_RATIO - 1);

    cdsc_state_t st;
    cdsc_state_t next_st;
    logic rise;
    logic accept;

    // one address decode shared by write, read and checks
    function automatic logic hits_ctrl(input logic [7:0] addr);
        return addr == cdsc_pkg::ADDR_SYNC_CONTROL;
    endfunction : hits_ctrl

    cdsc_edge u_edge (
        .clk_sys(clk_sys),
        .rst(rst),
        .sync_pin(sync_pin),
        .rise(rise)
    );

    // one-shot blocks later pulses via cleared gate
    assign accept = rise & st.ctrl[cdsc_pkg::BIT_MASTER_EN] & st.ctrl[cdsc_pkg::BIT_GATE];

    always_comb begin
        next_st = st;
        next_st.realign = accept;
        if (st.phase == LAST_PHASE) begin
            next_st.phase = '0;
        end else begin
            next_st.phase = st.phase + 1'b1;
        end
        if (st.realign) begin
            next_st.phase = '0;
        end
        // reserved bits are dropped so they always read back zero
        if (reg_wr && hits_ctrl(reg_addr)) begin
            next_st.ctrl = reg_wdata & cdsc_pkg::SYNC_CONTROL_WMASK;
        end
        if (accept && st.ctrl[cdsc_pkg::BIT_ONE_SHOT]) begin
            next_st.ctrl[cdsc_pkg::BIT_GATE] = 1'b0;
        end
        if (reg_rd) begin
            // read shows the gate before any hardware clear in the same cycle
            next_st.rdata = hits_ctrl(reg_addr) ? st.ctrl : 8'h00;
        end
        if (rst) begin
            next_st = '0;
            next_st.ctrl = cdsc_pkg::SYNC_CONTROL_RESET;
        end
    end

    always_ff @(posedge clk_sys) begin
        st <= next_st;
    end

    assign reg_rdata = st.rdata;
    assign div_phase = st.phase;
    assign realign = st.realign;
    assign sync_buf_on = st.ctrl[cdsc_pkg::BIT_MASTER_EN];

    chk_realign_after_edge: assert property (@(posedge clk_sys) disable iff (rst)
        accept |=> realign ##1 div_phase == '0)
        else $error("phase not zeroed after accepted edge");

    chk_master_blocks: assert property (@(posedge clk_sys) disable iff (rst)
        rise && !st.ctrl[cdsc_pkg::BIT_MASTER_EN] |=> !realign)
        else $error("realign without master enable");

    chk_continuous_mode: assert property (@(posedge clk_sys) disable iff (rst)
        rise && st.ctrl[1:0] == 2'b11 |=> realign)
        else $error("continuous mode missed pulse");

    sequence s_oneshot_hit;
        accept && st.ctrl[cdsc_pkg::BIT_ONE_SHOT];
    endsequence

    chk_oneshot_clear: assert property (@(posedge clk_sys) disable iff (rst)
        s_oneshot_hit |=> !st.ctrl[cdsc_pkg::BIT_GATE])
        else $error("gate not cleared in one-shot");

    chk_oneshot_single: assert property (@(posedge clk_sys) disable iff (rst)
        s_oneshot_hit ##1 !reg_wr [*2] |=> !realign)
        else $error("second pulse accepted in one-shot");

    chk_buffer_power: assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && reg_addr == cdsc_pkg::ADDR_SYNC_CONTROL |=> sync_buf_on == $past(reg_wdata[0]))
        else $error("buffer enable not written");

    chk_phase_wraps: assert property (@(posedge clk_sys) disable iff (rst)
        !realign && div_phase == LAST_PHASE |=> div_phase == '0)
        else $error("phase did not wrap");

    chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
        st.ctrl[7:3] == 5'h00)
        else $error("reserved bits set");

    chk_realign_single: assert property (@(posedge clk_sys) disable iff (rst)
        realign |=> !realign)
        else $error("realign longer than one cycle");

    chk_gate_blocks: assert property (@(posedge clk_sys) disable iff (rst)
        rise && !st.ctrl[cdsc_pkg::BIT_GATE] |=> !realign)
        else $error("realign with gate closed");

    chk_rdata_ctrl: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && hits_ctrl(reg_addr) |=> reg_rdata == $past(st.ctrl))
        else $error("control readback wrong");

    // only the gate bit is cleared
    chk_oneshot_keeps: assert property (@(posedge clk_sys) disable iff (rst)
        accept && st.ctrl[cdsc_pkg::BIT_ONE_SHOT] && !reg_wr |=> st.ctrl[2:0] == 3'h5)
        else $error("one-shot clear touched other bits");

    chk_write_ctrl: assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && hits_ctrl(reg_addr) && !accept
        |=> st.ctrl == ($past(reg_wdata) & cdsc_pkg::SYNC_CONTROL_WMASK))
        else $error("control write lost");

    chk_phase_step: assert property (@(posedge clk_sys) disable iff (rst)
        !realign && div_phase != LAST_PHASE
        |=> div_phase == cdsc_pkg::PHASE_W'($past(div_phase) + 1'b1))
        else $error("phase did not step");

    sequence s_pin_rise;
        $rose(sync_pin);
    endsequence

    sequence s_edge_seen;
        ##2 rise;
    endsequence

    chk_edge_latency: assert property (@(posedge clk_sys) disable iff (rst)
        s_pin_rise |-> s_edge_seen)
        else $error("edge not seen after two flops");

    chk_accept_needs_gate: assert property (@(posedge clk_sys) disable iff (rst)
        realign |-> $past(st.ctrl[cdsc_pkg::BIT_GATE]) && $past(st.ctrl[cdsc_pkg::BIT_MASTER_EN]))
        else $error("realign without enables");

    chk_master_idle: assert property (@(posedge clk_sys) disable iff (rst)
        !st.ctrl[cdsc_pkg::BIT_MASTER_EN] |-> !accept)
        else $error("accept with master low");

    chk_oneshot_gate_after: assert property (@(posedge clk_sys) disable iff (rst)
        realign && $past(st.ctrl[cdsc_pkg::BIT_ONE_SHOT]) |-> !st.ctrl[cdsc_pkg::BIT_GATE])
        else $error("gate open after one-shot");

    chk_rdata_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(rst) && !$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without read");

    chk_continuous_repeat: assert property (@(posedge clk_sys) disable iff (rst)
        accept && !st.ctrl[cdsc_pkg::BIT_ONE_SHOT] && !reg_wr |=> st.ctrl[cdsc_pkg::BIT_GATE])
        else $error("gate closed in continuous mode");

    chk_realign_needs_rise: assert property (@(posedge clk_sys) disable iff (rst)
        realign |-> $past(rise))
        else $error("realign without edge");

    chk_oneshot_blocks_pin: assert property (@(posedge clk_sys) disable iff (rst)
        rise && st.ctrl[2:0] == 3'h5 |=> !realign)
        else $error("pulse passed after one-shot");
endmodule : cdsc_top
`default_nettype wire

// ==== test/cdsc_pulse_src.sv ====
// sync pulse source standing in for the system timing logic
// assumes fire is a one-cycle request on clk_sys
`default_nettype none
module cdsc_pulse_src (
    // clock and request
    input wire logic clk_sys,
    input wire logic fire,
    // pulse out
    output logic sync_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt = 2'h0;
    // two cycles high, then held low until the next request
    always @(posedge clk_sys) begin
        cnt <= fire ? 2'h2 : cnt - {1'h0, cnt != 2'h0};
    end
    assign sync_pin = (cnt != 2'h0);
endmodule : cdsc_pulse_src
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the sync control block
// assumes cdsc_top and cdsc_pulse_src are compiled first
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, fire = 1'h0;
    logic rd_q = 1'h0, rl_q = 1'h0, sync_pin, realign, sync_buf_on;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [2:0] div_phase;
    logic [2:0] ph_q = 3'h0;
    logic rs_q = 1'h1;
    logic [31:0] seed = 32'h49743EB9;
    logic [2:0] mode [4] = '{3'h0, 3'h2, 3'h1, 3'h3};
    logic [7:0] rq [$];
    bit aq [$];
    int failures = 0, total_checks = 0;
    cdsc_top #(.DIV_RATIO(cdsc_pkg::DIV_RATIO_DEFAULT)) uut (.clk_sys(clk_sys),
        .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sync_pin(sync_pin),
        .div_phase(div_phase), .realign(realign), .sync_buf_on(sync_buf_on));
    cdsc_pulse_src src (.clk_sys(clk_sys), .fire(fire), .sync_pin(sync_pin));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction : xs
    task automatic bad(input string m);
        failures++;
        $display("BAD %0t %s", $time, m);
    endtask : bad
    task automatic close_out;
        if (failures == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    // one write or read; a read notes its expected data
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        if (!w) rq.push_back(d);
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        @(posedge clk_sys);
    endtask : acc
    task automatic pulse(input bit hit);
        fire <= 1'h1;
        if (hit) aq.push_back(1'b1);
        @(posedge clk_sys);
        fire <= 1'h0;
        repeat (9) @(posedge clk_sys);
    endtask : pulse
    always @(posedge clk_sys) begin
        rd_q <= reg_rd;
        rl_q <= realign;
        ph_q <= div_phase;
        rs_q <= rst;
        if (!rst && !rs_q) begin
            total_checks++;
            // ratio 8 wraps naturally in the 3-bit phase
            if (div_phase !== (rl_q ? 3'h0 : 3'(ph_q + 3'h1))) bad("phase step");
        end
        if (rd_q) begin
            total_checks++;
            if (reg_rdata !== rq.pop_front()) bad("read data");
        end
        if (realign === 1'h1) begin
            total_checks++;
            if (aq.size() == 0) bad("stray realign");
            else void'(aq.pop_front());
        end
        if (rl_q === 1'h1 && div_phase !== 3'h0) bad("phase not zeroed");
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        acc(0, 8'h3A, 8'h00);
        seed = xs(seed);
        acc(1, 8'h3B, seed[7:0]);
        acc(0, 8'h3B, 8'h00);
        foreach (mode[i]) begin
            seed = xs(seed);
            acc(1, 8'h3A, {seed[7:3], mode[i]});
            acc(0, 8'h3A, {5'h00, mode[i]});
            total_checks++;
            if (sync_buf_on !== mode[i][0]) bad("buffer enable");
            pulse(mode[i] == 3'h3);
            pulse(mode[i] == 3'h3);
        end
        acc(1, 8'h3A, 8'h07);
        pulse(1'b1);
        acc(0, 8'h3A, 8'h05);
        pulse(1'b0);
        acc(1, 8'h3A, 8'h00);
        total_checks++;
        if (aq.size() != 0) bad("missing realign");
        close_out();
    end
    initial begin
        #20000;
        bad("timeout");
        close_out();
    end
endmodule : tb
`default_nettype wire
